/* File: tllc_defines.vh */
// Constants for the touch-to-lamp link control block
//
// Notes on behaviour
// - Transition 0: linking untouched sensor with host bit set changes lamp.
// - Transition and inverted 1: linking keeps lamp; later touch changes it.
// - Transition 1, inverted 0: linking keeps lamp; later touches ignored.
// - Transition bits: channels 1-7 in bits 0-6 of A; 9, 10 in B.
// - Mirror bit 0: duty relative to 0%; bit 1: relative to 100%.
// - Polarity change copies into mirror bit unless mirror sync blocked.
// - Mirror bits: lamps 1-8 in register A bits 0-7; 9-11 in B.
// - Linked channel drives lamp from touch and release of its own sensor.
// - Channel set as general-purpose input ignores its link bit.
// - Group link bit 7: up slide, tap or hold actuates lamp 10.
// - Group link bit: down slide, tap or hold actuates lamp 9.
// - Lamps 9 and 10 never active together; actuating one drops the other.
// - Link bit 0: touch does not actuate; host bits alone control lamp.
// - Link bit 1: touch actuates lamp and lamp output is enabled.
// - Link bits for sensors 1-7 sit in bits 0-6, sensor n to lamp n.
// - Transition settings act only while linked, with the inverted bit.
// - Touch on a linked sensor acts like host request bit set.
// - Linking lamp 10 to the group also links lamp 9.
`ifndef TLLC_DEFINES_VH
`define TLLC_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define TLLC_ADDR_TRANS_A 8'h77
`define TLLC_ADDR_TRANS_B 8'h78
`define TLLC_ADDR_MIRROR_A 8'h79
`define TLLC_ADDR_MIRROR_B 8'h7a
`define TLLC_ADDR_LINKING 8'h80

// ****************************************
// Reset values
// ****************************************
`define TLLC_RST_TRANS_A 7'h00
`define TLLC_RST_TRANS_B 2'h0
`define TLLC_RST_MIRROR_A 8'h00
`define TLLC_RST_MIRROR_B 3'h0
`define TLLC_RST_LINKING 8'h00

// ****************************************
// Field positions
// ****************************************
`define TLLC_TRANS_A_W 7
`define TLLC_TRANS_B_W 2
`define TLLC_MIRROR_B_W 3
`define TLLC_GROUP_LINK_BIT 7
`define TLLC_LAMP9 8
`define TLLC_LAMP10 9
`define TLLC_LAMP_COUNT 11
`define TLLC_GPIO_COUNT 8
`define TLLC_SENSOR_COUNT 7

`endif

/* File: tllc_chan_link.v */
// One linkable lamp channel: link edge handling and actuate selection
`timescale 1ns/10ps
module tllc_chan_link (
  ref_clk,
  rst,
  linkReq,
  transitionSel,
  invertedTransitionEnable,
  sensorTouched,
  hostLampRequest,
  lampActuate,
  holdActive
);
  input wire ref_clk;
  input wire rst;
  input wire linkReq;
  input wire transitionSel;
  input wire invertedTransitionEnable;
  input wire sensorTouched;
  input wire hostLampRequest;
  output wire lampActuate;
  output wire holdActive;

  reg linkDly_ff;
  reg hold_ff;
  reg nxt_hold;
  wire linkRise;
  wire heldValue;

  // ****************************************
  // Transition hold
  // ****************************************
  assign linkRise = linkReq & ~linkDly_ff;

  // Hold is only entered at the link edge and lasts while linked
  always @* begin
    nxt_hold = hold_ff;
    if (!linkReq) begin
      nxt_hold = 1'b0;
    end else if (linkRise && hostLampRequest && !sensorTouched &&
                 transitionSel) begin
      nxt_hold = 1'b1;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      linkDly_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      linkDly_ff <= linkReq;
      hold_ff <= nxt_hold;
    end
  end

  // ****************************************
  // Actuate selection
  // ****************************************
  // Inverted hold flips on touch; plain hold ignores touches
  assign heldValue = invertedTransitionEnable ? ~sensorTouched :
                     1'b1;
  // Without hold a linked lamp follows the touch, so it drops at link
  assign lampActuate = linkReq ? (nxt_hold ? heldValue : sensorTouched) :
                       hostLampRequest;
  assign holdActive = hold_ff;
endmodule

/* File: tllc_top.v */
// Touch-to-lamp link control: registers, channel links, group, mirror
`timescale 1ns/10ps
`include "tllc_defines.vh"
module tllc_top (
  ref_clk,
  rst,
  regAddr,
  regWrData,
  regWrEn,
  regRdEn,
  regRdData,
  touchSensor,
  groupUpEvent,
  groupDownEvent,
  groupReleaseEvent,
  hostLampRequest,
  hostLampEnable,
  lampPolarity,
  gpioInputMode,
  invertedTransitionEnable,
  blockPolarityMirrorSync,
  lampActuate,
  lampEnable,
  dutyMirror,
  transitionHold
);
  // ****************************************
  // Ports
  // ****************************************
  input wire ref_clk;
  input wire rst;
  input wire [7:0] regAddr;
  input wire [7:0] regWrData;
  input wire regWrEn;
  input wire regRdEn;
  output wire [7:0] regRdData;
  input wire [6:0] touchSensor;
  input wire groupUpEvent;
  input wire groupDownEvent;
  input wire groupReleaseEvent;
  input wire [10:0] hostLampRequest;
  input wire [10:0] hostLampEnable;
  input wire [10:0] lampPolarity;
  input wire [7:0] gpioInputMode;
  input wire invertedTransitionEnable;
  input wire blockPolarityMirrorSync;
  output wire [10:0] lampActuate;
  output wire [10:0] lampEnable;
  output wire [10:0] dutyMirror;
  output wire [8:0] transitionHold;

  // ****************************************
  // Register storage
  // ****************************************
  reg [6:0] transA_ff;
  reg [1:0] transB_ff;
  reg [7:0] mirrorA_ff;
  reg [2:0] mirrorB_ff;
  reg [7:0] linking_ff;
  reg [7:0] rdData_ff;
  reg [7:0] nxt_rdData;
  reg [7:0] nxt_mirrorA;
  reg [2:0] nxt_mirrorB;

  // ****************************************
  // Group state and output registers
  // ****************************************
  reg upActive_ff;
  reg downActive_ff;
  reg nxt_upActive;
  reg nxt_downActive;
  reg [10:0] polDly_ff;
  reg [10:0] actuate_ff;
  reg [10:0] enable_ff;

  wire [10:0] polChanged;
  wire [10:0] mirrorLoad;
  wire [10:0] gpioWide;
  wire [10:0] effLink;
  wire [10:0] chanActuate;
  wire [8:0] chanLink;
  wire [8:0] chanTrans;
  wire [8:0] chanTouch;
  wire [8:0] chanHost;
  wire [8:0] chanOut;
  wire groupLink;
  wire wrTransA;
  wire wrTransB;
  wire wrMirrorA;
  wire wrMirrorB;
  wire wrLinking;
  wire pairClash;
  wire lamp9Out;
  wire lamp10Out;

  // ****************************************
  // Write decode
  // ****************************************
  assign wrTransA = regWrEn && (regAddr == `TLLC_ADDR_TRANS_A);
  assign wrTransB = regWrEn && (regAddr == `TLLC_ADDR_TRANS_B);
  assign wrMirrorA = regWrEn && (regAddr == `TLLC_ADDR_MIRROR_A);
  assign wrMirrorB = regWrEn && (regAddr == `TLLC_ADDR_MIRROR_B);
  assign wrLinking = regWrEn && (regAddr == `TLLC_ADDR_LINKING);

  // Unused bit positions are never stored
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      transA_ff <= `TLLC_RST_TRANS_A;
    end else if (wrTransA) begin
      transA_ff <= regWrData[6:0];
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      transB_ff <= `TLLC_RST_TRANS_B;
    end else if (wrTransB) begin
      transB_ff <= regWrData[1:0];
    end
  end

  // ****************************************
  // Linking register
  // ****************************************
  // Bit 7 is the group link, bits 0-6 pair sensor n with lamp n
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      linking_ff <= `TLLC_RST_LINKING;
    end else if (wrLinking) begin
      linking_ff <= regWrData;
    end
  end

  // ****************************************
  // Duty mirror bits
  // ****************************************
  // A polarity edge rewrites the mirror bit. It wins over a software
  // write in the same cycle so the two never disagree after a change.
  assign polChanged = lampPolarity ^ polDly_ff;
  assign mirrorLoad = blockPolarityMirrorSync ? 11'h000 : polChanged;

  always @* begin
    nxt_mirrorA = mirrorA_ff;
    nxt_mirrorB = mirrorB_ff;
    if (wrMirrorA) begin
      nxt_mirrorA = regWrData;
    end
    if (wrMirrorB) begin
      nxt_mirrorB = regWrData[2:0];
    end
    nxt_mirrorA = (nxt_mirrorA & ~mirrorLoad[7:0]) |
                  (lampPolarity[7:0] & mirrorLoad[7:0]);
    nxt_mirrorB = (nxt_mirrorB & ~mirrorLoad[10:8]) |
                  (lampPolarity[10:8] & mirrorLoad[10:8]);
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mirrorA_ff <= `TLLC_RST_MIRROR_A;
      mirrorB_ff <= `TLLC_RST_MIRROR_B;
    end else begin
      mirrorA_ff <= nxt_mirrorA;
      mirrorB_ff <= nxt_mirrorB;
    end
  end

  // ****************************************
  // Polarity history
  // ****************************************
  // Clears to the reset polarity, so a bit already high at release
  // counts as a change one edge later
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      polDly_ff <= 11'h000;
    end else begin
      polDly_ff <= lampPolarity;
    end
  end

  // ****************************************
  // Duty mirror output
  // ****************************************
  // The duty engine reads these to bias duty to 0% or 100%
  assign dutyMirror = {mirrorB_ff, mirrorA_ff};

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    nxt_rdData = rdData_ff;
    if (regRdEn) begin
      case (regAddr)
        `TLLC_ADDR_TRANS_A: begin
          nxt_rdData = {1'b0, transA_ff};
        end
        `TLLC_ADDR_TRANS_B: begin
          nxt_rdData = {6'h00, transB_ff};
        end
        `TLLC_ADDR_MIRROR_A: begin
          nxt_rdData = mirrorA_ff;
        end
        `TLLC_ADDR_MIRROR_B: begin
          nxt_rdData = {5'h00, mirrorB_ff};
        end
        `TLLC_ADDR_LINKING: begin
          nxt_rdData = linking_ff;
        end
        default: begin
          nxt_rdData = 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  // Holds the last read so a slow host can still take it later
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;

  // ****************************************
  // Link qualification
  // ****************************************
  // Lamps 9 to 11 have no input mode, so only the first eight gate
  assign gpioWide = {3'h0, gpioInputMode};
  assign groupLink = linking_ff[`TLLC_GROUP_LINK_BIT];
  // One bit links both group lamps, so lamp 9 follows lamp 10
  assign effLink = {1'b0, groupLink, groupLink, 1'b0, linking_ff[6:0]} &
                   ~gpioWide;

  // ****************************************
  // Group up and down
  // ****************************************
  // Up wins if both directions arrive together; a release with no
  // direction in the same cycle, or an unlink, drops both lamps.
  always @* begin
    nxt_upActive = upActive_ff;
    nxt_downActive = downActive_ff;
    if (!groupLink || groupReleaseEvent) begin
      nxt_upActive = 1'b0;
      nxt_downActive = 1'b0;
    end
    if (groupLink && groupUpEvent) begin
      nxt_upActive = 1'b1;
      nxt_downActive = 1'b0;
    end else if (groupLink && groupDownEvent) begin
      nxt_downActive = 1'b1;
      nxt_upActive = 1'b0;
    end
  end

  // ****************************************
  // Group state registers
  // ****************************************
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upActive_ff <= 1'b0;
    end else begin
      upActive_ff <= nxt_upActive;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      downActive_ff <= 1'b0;
    end else begin
      downActive_ff <= nxt_downActive;
    end
  end

  // ****************************************
  // Channel links
  // ****************************************
  // Slots 0-6 are lamps 1-7, slot 7 is lamp 9, slot 8 is lamp 10
  assign chanLink = {effLink[`TLLC_LAMP10], effLink[`TLLC_LAMP9],
                     effLink[6:0]};
  assign chanTrans = {transB_ff, transA_ff};
  assign chanTouch = {upActive_ff, downActive_ff, touchSensor};
  assign chanHost = {hostLampRequest[`TLLC_LAMP10],
                     hostLampRequest[`TLLC_LAMP9], hostLampRequest[6:0]};

  // ****************************************
  // Channel instances
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : gChan
      tllc_chan_link uChan (
        .ref_clk(ref_clk),
        .rst(rst),
        .linkReq(chanLink[gi]),
        .transitionSel(chanTrans[gi]),
        .invertedTransitionEnable(invertedTransitionEnable),
        .sensorTouched(chanTouch[gi]),
        .hostLampRequest(chanHost[gi]),
        .lampActuate(chanOut[gi]),
        .holdActive(transitionHold[gi])
      );
    end
  endgenerate

  // ****************************************
  // Group pair exclusion
  // ****************************************
  // A held lamp can stay on while its partner is actuated. The
  // direction seen last decides, lamp 10 when neither is seen.
  assign pairClash = chanOut[7] & chanOut[8];
  assign lamp10Out = chanOut[8] & ~(pairClash & downActive_ff);
  assign lamp9Out = chanOut[7] & ~lamp10Out;

  // Lamps 8 and 11 cannot be linked and always follow the host
  assign chanActuate = {hostLampRequest[10], lamp10Out, lamp9Out,
                        hostLampRequest[7], chanOut[6:0]};

  // ****************************************
  // Output registers
  // ****************************************
  // One cycle of latency buys glitch-free requests to the duty engine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      actuate_ff <= 11'h000;
    end else begin
      actuate_ff <= chanActuate;
    end
  end

  // A link turns the output on even when the host leaves it off
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_ff <= 11'h000;
    end else begin
      enable_ff <= hostLampEnable | effLink;
    end
  end

  // ****************************************
  // Register outputs
  // ****************************************
  assign lampActuate = actuate_ff;
  assign lampEnable = enable_ff;
endmodule

/* File: tllc_chk.sv */
// Port checker for the touch-to-lamp link control block
`timescale 1ns/10ps
module tllc_chk (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regRdData,
  input wire [6:0] touchSensor,
  input wire groupUpEvent,
  input wire groupDownEvent,
  input wire groupReleaseEvent,
  input wire [10:0] hostLampRequest,
  input wire [10:0] hostLampEnable,
  input wire [10:0] lampPolarity,
  input wire [7:0] gpioInputMode,
  input wire invertedTransitionEnable,
  input wire blockPolarityMirrorSync,
  input wire [10:0] lampActuate,
  input wire [10:0] lampEnable,
  input wire [10:0] dutyMirror,
  input wire [8:0] transitionHold
);
  // ****************************************
  // Shadow of the linking byte
  // ****************************************
  // Kept here because the link state is not visible at the ports
  logic [7:0] lnkSh_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      lnkSh_ff <= 8'h00;
    else if (regWrEn && regAddr == 8'h80)
      lnkSh_ff <= regWrData;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Properties
  // ****************************************
  sequence s_steady;
    $past(lnkSh_ff[0]) && lnkSh_ff[0] && !gpioInputMode[0] &&
      !transitionHold[0] ##1 !transitionHold[0];
  endsequence
  property p_free;
    s_steady |-> lampActuate[0] == $past(touchSensor[0]);
  endproperty
  a_free: assert property (p_free) else $error("touch not followed");
  property p_unl;
    !lnkSh_ff[0] || gpioInputMode[0] |=>
      lampActuate[0] == $past(hostLampRequest[0]);
  endproperty
  a_unl: assert property (p_unl) else $error("host bit ignored");
  property p_en;
    lnkSh_ff[0] && !gpioInputMode[0] |=> lampEnable[0];
  endproperty
  a_en: assert property (p_en) else $error("linked lamp off");
  property p_hold;
    transitionHold[0] && lnkSh_ff[0] && !gpioInputMode[0] |=> lampActuate[0]
      == (!$past(invertedTransitionEnable) || !$past(touchSensor[0]));
  endproperty
  a_hold: assert property (p_hold) else $error("hold wrong");
  property p_up;
    lnkSh_ff[7] && groupUpEvent |-> ##2 lampActuate[9] && !lampActuate[8];
  endproperty
  a_up: assert property (p_up) else $error("up missed");
  property p_dn;
    lnkSh_ff[7] && groupDownEvent && !groupUpEvent |->
      ##2 lampActuate[8] && !lampActuate[9];
  endproperty
  a_dn: assert property (p_dn) else $error("down missed");
  property p_mutex;
    !(lampActuate[8] && lampActuate[9]);
  endproperty
  a_mutex: assert property (p_mutex) else $error("both group lamps");
  property p_mir;
    !blockPolarityMirrorSync && lampPolarity != $past(lampPolarity) |=>
      ((dutyMirror ^ $past(lampPolarity)) &
      ($past(lampPolarity) ^ $past(lampPolarity, 2))) == 11'h000;
  endproperty
  a_mir: assert property (p_mir) else $error("mirror not copied");
  property p_unmap;
    regRdEn && !(regAddr inside {8'h77, 8'h78, 8'h79, 8'h7a, 8'h80})
      |=> regRdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
endmodule

/* File: tllc_host_model.sv */
// Host model that reaches the registers over the register port
`timescale 1ns/10ps
module tllc_host_model (
  input wire ref_clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // ****************************************
  // Accesses
  // ****************************************
  // Idle lines are inverted so a stale value is never relied on
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
endmodule

/* File: tb_top.sv */
// Testbench top for the touch-to-lamp link control block
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wire [7:0] regAddr;
  wire [7:0] regWrData;
  wire regWrEn;
  wire regRdEn;
  wire [7:0] regRdData;
  logic [6:0] touchSensor = 7'h00;
  logic groupUpEvent = 1'b0;
  logic groupDownEvent = 1'b0;
  logic groupReleaseEvent = 1'b0;
  logic [10:0] hostLampRequest = 11'h000;
  logic [10:0] hostLampEnable = 11'h000;
  logic [10:0] lampPolarity = 11'h000;
  logic [7:0] gpioInputMode = 8'h00;
  logic invertedTransitionEnable = 1'b1;
  logic blockPolarityMirrorSync = 1'b0;
  wire [10:0] lampActuate;
  wire [10:0] lampEnable;
  wire [10:0] dutyMirror;
  wire [8:0] transitionHold;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] rdv;
  always #2.5 ref_clk = ~ref_clk;
  tllc_top dut (.ref_clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .touchSensor, .groupUpEvent, .groupDownEvent,
    .groupReleaseEvent, .hostLampRequest, .hostLampEnable, .lampPolarity,
    .gpioInputMode, .invertedTransitionEnable, .blockPolarityMirrorSync,
    .lampActuate, .lampEnable, .dutyMirror, .transitionHold);
  tllc_host_model host (.ref_clk, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData);
  // ****************************************
  // Checking and scenarios
  // ****************************************
  task chk(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task regchk(input logic [7:0] a, input logic [7:0] m);
    host.rd(a, rdv);
    chk({3'h0, rdv}, 11'h000);
    host.wr(a, 8'hff);
    host.rd(a, rdv);
    chk({3'h0, rdv}, {3'h0, m});
    host.wr(a, 8'h00);
  endtask
  task t_regs;
    regchk(8'h77, 8'h7f);
    regchk(8'h78, 8'h03);
    regchk(8'h79, 8'hff);
    regchk(8'h7a, 8'h07);
    regchk(8'h80, 8'hff);
    regchk(8'h7b, 8'h00);
  endtask
  task t_link;
    @(negedge ref_clk);
    hostLampRequest = 11'h001;
    host.wr(8'h80, 8'h01);
    chk(lampActuate[0], 1'b1);
    repeat (2) @(negedge ref_clk);
    chk(lampActuate[0], 1'b0);
    chk(lampEnable[0], 1'b1);
    touchSensor = 7'h01;
    repeat (2) @(negedge ref_clk);
    chk(lampActuate[0], 1'b1);
    host.wr(8'h80, 8'h00);
    hostLampRequest = 11'h000;
    repeat (2) @(negedge ref_clk);
    chk(lampActuate[0], 1'b0);
    chk(lampEnable[0], 1'b0);
    hostLampEnable = 11'h001;
    repeat (2) @(negedge ref_clk);
    chk(lampEnable[0], 1'b1);
    hostLampEnable = 11'h000;
    touchSensor = 7'h00;
  endtask
  // Non-inverted run is legal here only because behaviour is direct
  task t_hold(input logic inv);
    @(negedge ref_clk);
    invertedTransitionEnable = inv;
    hostLampRequest = 11'h001;
    host.wr(8'h77, 8'h01);
    host.wr(8'h80, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk({lampActuate[0], transitionHold[0]}, 2'b11);
    touchSensor = 7'h01;
    repeat (2) @(negedge ref_clk);
    chk(lampActuate[0], !inv);
    touchSensor = 7'h00;
    host.wr(8'h80, 8'h00);
    host.wr(8'h77, 8'h00);
    invertedTransitionEnable = 1'b1;
  endtask
  task t_gpio;
    @(negedge ref_clk);
    gpioInputMode = 8'h01;
    host.wr(8'h77, 8'h01);
    host.wr(8'h80, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk({lampActuate[0], transitionHold[0]}, 2'b10);
    chk(lampEnable[0], 1'b0);
    host.wr(8'h80, 8'h00);
    host.wr(8'h77, 8'h00);
    gpioInputMode = 8'h00;
  endtask
  task grp(input logic [2:0] ev, input logic [1:0] exp);
    @(negedge ref_clk);
    {groupUpEvent, groupDownEvent, groupReleaseEvent} = ev;
    @(negedge ref_clk);
    {groupUpEvent, groupDownEvent, groupReleaseEvent} = 3'b000;
    repeat (2) @(negedge ref_clk);
    chk(lampActuate[9:8], exp);
  endtask
  task t_group;
    host.wr(8'h80, 8'h80);
    grp(3'b100, 2'b10);
    grp(3'b010, 2'b01);
    grp(3'b110, 2'b10);
    grp(3'b001, 2'b00);
    host.wr(8'h80, 8'h00);
    grp(3'b100, 2'b00);
  endtask
  task t_mirror;
    @(negedge ref_clk);
    lampPolarity = 11'h004;
    repeat (2) @(negedge ref_clk);
    chk(dutyMirror, 11'h004);
    host.rd(8'h79, rdv);
    chk({3'h0, rdv}, 11'h004);
    blockPolarityMirrorSync = 1'b1;
    lampPolarity = 11'h404;
    repeat (2) @(negedge ref_clk);
    chk(dutyMirror, 11'h004);
    blockPolarityMirrorSync = 1'b0;
    lampPolarity = 11'h400;
    repeat (2) @(negedge ref_clk);
    chk(dutyMirror, 11'h000);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_regs;
    t_link;
    t_hold(1'b1);
    t_hold(1'b0);
    t_gpio;
    t_group;
    t_mirror;
    print_verdict;
  end
  // Guard against a hang
  initial begin
    #200000;
    fails++;
    print_verdict;
  end
endmodule
bind tllc_top tllc_chk chk (.ref_clk, .rst, .regAddr, .regWrData, .regWrEn,
  .regRdEn, .regRdData, .touchSensor, .groupUpEvent, .groupDownEvent,
  .groupReleaseEvent, .hostLampRequest, .hostLampEnable, .lampPolarity,
  .gpioInputMode, .invertedTransitionEnable, .blockPolarityMirrorSync,
  .lampActuate, .lampEnable, .dutyMirror, .transitionHold);
